// ===== rtl/csfs_axil_slave.sv
// AXI4-Lite slave front end: channel handshakes, one write and one read at a time
// assumes the owner decodes addresses combinationally and returns read data and errors
`timescale 1ns/1ps

module csfs_axil_slave (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [7:0] awaddr_i,
  input wire logic awvalid_i,
  output logic awready_o,
  input wire logic [31:0] wdata_i,
  input wire logic [3:0] wstrb_i,
  input wire logic wvalid_i,
  output logic wready_o,
  output logic [1:0] bresp_o,
  output logic bvalid_o,
  input wire logic bready_i,
  input wire logic [7:0] araddr_i,
  input wire logic arvalid_i,
  output logic arready_o,
  output logic [31:0] rdata_o,
  output logic [1:0] rresp_o,
  output logic rvalid_o,
  input wire logic rready_i,
  output logic wr_en_o,
  output logic [7:0] wr_addr_o,
  output logic [31:0] wr_data_o,
  output logic [3:0] wr_strb_o,
  input wire logic wr_err_i,
  output logic [7:0] rd_addr_o,
  input wire logic [31:0] rd_data_i,
  input wire logic rd_err_i
);

  logic aw_full_q;
  logic w_full_q;

  assign awready_o = !aw_full_q && !bvalid_o;
  assign wready_o = !w_full_q && !bvalid_o;
  assign arready_o = !rvalid_o;
  assign rd_addr_o = araddr_i;
  assign wr_en_o = aw_full_q && w_full_q;

  // ****************************************
  // write path
  // ****************************************
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      aw_full_q <= 1'b0;
      w_full_q <= 1'b0;
      wr_addr_o <= 8'h00;
      wr_data_o <= 32'h0000_0000;
      wr_strb_o <= 4'h0;
      bvalid_o <= 1'b0;
      bresp_o <= 2'b00;
    end else begin
      if (awvalid_i && awready_o) begin
        aw_full_q <= 1'b1;
        wr_addr_o <= awaddr_i;
      end
      if (wvalid_i && wready_o) begin
        w_full_q <= 1'b1;
        wr_data_o <= wdata_i;
        wr_strb_o <= wstrb_i;
      end
      if (wr_en_o) begin
        aw_full_q <= 1'b0;
        w_full_q <= 1'b0;
        bvalid_o <= 1'b1;
        bresp_o <= wr_err_i ? 2'b10 : 2'b00;
      end else if (bvalid_o && bready_i) begin
        bvalid_o <= 1'b0;
      end
    end
  end

  // ****************************************
  // read path
  // ****************************************
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rvalid_o <= 1'b0;
      rdata_o <= 32'h0000_0000;
      rresp_o <= 2'b00;
    end else if (arvalid_i && arready_o) begin
      rvalid_o <= 1'b1;
      rdata_o <= rd_err_i ? 32'h0000_0000 : rd_data_i;
      rresp_o <= rd_err_i ? 2'b10 : 2'b00;
    end else if (rvalid_o && rready_i) begin
      rvalid_o <= 1'b0;
    end
  end

endmodule // csfs_axil_slave

// ===== rtl/csfs_cfg.svh
// constants of the creep and speed fault supervisor: offsets, fields, resets, timing
// assumes a 40 MHz system clock and 32-bit word-aligned register offsets
`ifndef CSFS_CFG_SVH
`define CSFS_CFG_SVH

// ****************************************
// register offsets
// ****************************************
`define CSFS_OFS_CTRL 8'h00
`define CSFS_OFS_MAX_SPEED 8'h04
`define CSFS_OFS_SETTLE_SPEED 8'h08
`define CSFS_OFS_TOLERANCE 8'h0c
`define CSFS_OFS_BRAKE_TMO 8'h10
`define CSFS_OFS_FAULTS 8'h14
`define CSFS_OFS_INT_STATUS 8'h18
`define CSFS_OFS_INT_CLEAR 8'h1c
`define CSFS_OFS_INT_ENABLE 8'h20
`define CSFS_OFS_FAULT_CODE 8'h24
`define CSFS_OFS_PDO_COUNT 8'h28

// ****************************************
// fields and reset values
// ****************************************
`define CSFS_CTRL_CAN_BIT 0
`define CSFS_CTRL_KIND_LSB 1
`define CSFS_CTRL_KIND_MSB 2
`define CSFS_CTRL_RST 32'h0000_0002
`define CSFS_MAX_SPEED_RST 16'h0fa0
`define CSFS_SETTLE_SPEED_RST 16'h0064
`define CSFS_TOLERANCE_RST 16'h00c8
`define CSFS_BRAKE_TMO_RST 16'h03e8
`define CSFS_NUM_EVT 9
`define CSFS_SPEED_LSB 4
`define CSFS_PDO_FIRST 4'ha
`define CSFS_PDO_CLEAR 4'hb
`define CSFS_NUM_PINS 5

// ****************************************
// timing
// ****************************************
`define CSFS_CLK_HZ 40000000
`define CSFS_OVERSPEED_MS 500
`define CSFS_CURVE_MS 64
`define CSFS_MAXSPEED_MS 2000
`define CSFS_MS_CYC (`CSFS_CLK_HZ / 1000)
`define CSFS_OVERSPEED_CYC (`CSFS_MS_CYC * `CSFS_OVERSPEED_MS)
`define CSFS_CURVE_CYC (`CSFS_MS_CYC * `CSFS_CURVE_MS)
`define CSFS_MAXSPEED_CYC (`CSFS_MS_CYC * `CSFS_MAXSPEED_MS)
`define CSFS_CNT_W 27

`endif

// ===== rtl/csfs_dur_timer.sv
// duration timer: flags a condition that has held for more than a cycle count
// assumes cond_i comes from logic on the same clock
`timescale 1ns/1ps
`include "csfs_cfg.svh"

module csfs_dur_timer #(
  parameter logic [`CSFS_CNT_W-1:0] LIMIT = 27'd1
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cond_i,
  output logic over_o
);

  logic [`CSFS_CNT_W-1:0] cnt_q;

  // count restarts as soon as the condition drops
  always_ff @(posedge clk_i) begin
    if (rst_i || !cond_i) begin
      cnt_q <= '0;
    end else if (cnt_q != LIMIT) begin
      cnt_q <= cnt_q + 1'b1;
    end
  end

  // over once the condition outlasts the full limit
  assign over_o = cond_i && (cnt_q == LIMIT);

endmodule // csfs_dur_timer

// ===== rtl/csfs_pkg.sv
// types of the creep and speed fault supervisor
// assumes nothing beyond the configuration header
package csfs_pkg;

  // fault group reported beside the type number
  typedef enum logic [1:0] {
    CSFS_GRP_NONE = 2'b00,
    CSFS_GRP_CREEP = 2'b01,
    CSFS_GRP_SPEED = 2'b10
  } csfs_group_t;

  // creep brake window against the interlock brake timeout
  typedef enum logic [1:0] {
    CSFS_BRK_IDLE = 2'b00,
    CSFS_BRK_TIMING = 2'b01,
    CSFS_BRK_EXPIRED = 2'b10
  } csfs_brk_t;

endpackage

// ===== rtl/csfs_supervisor.sv
// creep sequencing and speed supervision faults with their shutdown actions
// assumes switch pins are asynchronous; speed, curve and state inputs are on SYS_CLK_I
// Notes on behaviour
// - standard variant: creep active at interlock turn-on gives creep type 1, throttle off
// - bus variant: creep active during first 10 process messages gives creep type 1
// - interlock turning off while creep active gives creep type 2, throttle off
// - creep active when interlock turns on gives creep type 3, throttle off
// - creep types 2 and 3 hold until interlock and creep both off
// - brake exit before interlock brake timeout in creep brake gives type 4
// - type 4 clears below settle speed, reverse off, interlock off, neutral; kind 0 blocks
// - speed above 120 percent of maximum for over 500ms gives speed type 1
// - speed outside curve over 64ms while decelerating gives speed type 2
// - speed outside curve over 64ms in interlock braking gives speed type 3
// - speed outside curve over 64ms in emergency reverse gives speed type 4
// - speed above maximum for over two seconds gives speed type 5
// - speed faults drop interlock status and brake driver, latched until keyswitch
`timescale 1ns/1ps
`include "csfs_cfg.svh"

module csfs_supervisor import csfs_pkg::*; #(
  parameter logic [`CSFS_CNT_W-1:0] OVERSPEED_CYC = `CSFS_CNT_W'(`CSFS_OVERSPEED_CYC),
  parameter logic [`CSFS_CNT_W-1:0] CURVE_CYC = `CSFS_CNT_W'(`CSFS_CURVE_CYC),
  parameter logic [`CSFS_CNT_W-1:0] MAXSPEED_CYC = `CSFS_CNT_W'(`CSFS_MAXSPEED_CYC),
  parameter logic [15:0] MS_CYC = 16'(`CSFS_MS_CYC)
) (
  input wire logic SYS_CLK_I,
  input wire logic RST_I,
  input wire logic INTERLOCK_I,
  input wire logic CREEP_I,
  input wire logic EMR_I,
  input wire logic THROTTLE_NEUTRAL_I,
  input wire logic BRAKE_EXIT_I,
  input wire logic CREEP_BRAKE_STATE_I,
  input wire logic DECEL_I,
  input wire logic ILOCK_BRAKING_I,
  input wire logic PDO_RX_I,
  input wire logic [15:0] MOTOR_RPM_I,
  input wire logic [15:0] CURVE_RPM_I,
  input wire logic [7:0] S_AXI_AWADDR_I,
  input wire logic S_AXI_AWVALID_I,
  output logic S_AXI_AWREADY_O,
  input wire logic [31:0] S_AXI_WDATA_I,
  input wire logic [3:0] S_AXI_WSTRB_I,
  input wire logic S_AXI_WVALID_I,
  output logic S_AXI_WREADY_O,
  output logic [1:0] S_AXI_BRESP_O,
  output logic S_AXI_BVALID_O,
  input wire logic S_AXI_BREADY_I,
  input wire logic [7:0] S_AXI_ARADDR_I,
  input wire logic S_AXI_ARVALID_I,
  output logic S_AXI_ARREADY_O,
  output logic [31:0] S_AXI_RDATA_O,
  output logic [1:0] S_AXI_RRESP_O,
  output logic S_AXI_RVALID_O,
  input wire logic S_AXI_RREADY_I,
  output logic THROTTLE_SHUTDOWN_O,
  output logic ILOCK_SHUTDOWN_O,
  output logic EMBRAKE_SHUTDOWN_O,
  output logic [1:0] FAULT_GROUP_O,
  output logic [2:0] FAULT_TYPE_O,
  output logic IRQ_O
);

  // ****************************************
  // pin synchronisers
  // ****************************************
  logic [`CSFS_NUM_PINS-1:0] pin_raw;
  logic [`CSFS_NUM_PINS-1:0] pin_q;
  logic ilock;
  logic creep;
  logic emr;
  logic neutral;
  logic brake_exit;

  assign pin_raw = {BRAKE_EXIT_I, THROTTLE_NEUTRAL_I, EMR_I, CREEP_I, INTERLOCK_I};
  assign {brake_exit, neutral, emr, creep, ilock} = pin_q;

  genvar gi;
  generate
    for (gi = 0; gi < `CSFS_NUM_PINS; gi++) begin : g_sync
      logic s1_q;
      logic s2_q;
      logic s3_q;
      // a change counts once the second and third stages agree
      always_ff @(posedge SYS_CLK_I) begin
        if (RST_I) begin
          s1_q <= 1'b0;
          s2_q <= 1'b0;
          s3_q <= 1'b0;
          pin_q[gi] <= 1'b0;
        end else begin
          s1_q <= pin_raw[gi];
          s2_q <= s1_q;
          s3_q <= s2_q;
          if (s2_q == s3_q) begin
            pin_q[gi] <= s3_q;
          end
        end
      end
    end
  endgenerate

  logic ilock_prev_q;
  logic ilock_on;
  logic ilock_off;

  always_ff @(posedge SYS_CLK_I) begin
    if (RST_I) begin
      ilock_prev_q <= 1'b0;
    end else begin
      ilock_prev_q <= ilock;
    end
  end

  assign ilock_on = ilock && !ilock_prev_q;
  assign ilock_off = !ilock && ilock_prev_q;

  // ****************************************
  // registers
  // ****************************************
  logic wr_en;
  logic [7:0] wr_addr;
  logic [31:0] wr_data;
  logic [3:0] wr_strb;
  logic [7:0] rd_addr;
  logic [31:0] rd_data;
  logic [31:0] ctrl_q;
  logic [15:0] max_speed_q;
  logic [15:0] settle_speed_q;
  logic [15:0] tolerance_q;
  logic [15:0] brake_tmo_q;
  logic [`CSFS_NUM_EVT-1:0] int_status_q;
  logic [`CSFS_NUM_EVT-1:0] int_enable_q;
  logic can_variant;
  logic [1:0] brake_kind;

  // known register offsets
  function automatic logic addr_ok(input logic [7:0] a);
    addr_ok = (a[1:0] == 2'b00) && (a <= `CSFS_OFS_PDO_COUNT);
  endfunction

  // merge a write into a register under byte strobes
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] strb);
    for (int b = 0; b < 4; b++) begin
      merge[8*b +: 8] = strb[b] ? nw[8*b +: 8] : old[8*b +: 8];
    end
  endfunction

  csfs_axil_slave u_bus (
    .clk_i(SYS_CLK_I),
    .rst_i(RST_I),
    .awaddr_i(S_AXI_AWADDR_I),
    .awvalid_i(S_AXI_AWVALID_I),
    .awready_o(S_AXI_AWREADY_O),
    .wdata_i(S_AXI_WDATA_I),
    .wstrb_i(S_AXI_WSTRB_I),
    .wvalid_i(S_AXI_WVALID_I),
    .wready_o(S_AXI_WREADY_O),
    .bresp_o(S_AXI_BRESP_O),
    .bvalid_o(S_AXI_BVALID_O),
    .bready_i(S_AXI_BREADY_I),
    .araddr_i(S_AXI_ARADDR_I),
    .arvalid_i(S_AXI_ARVALID_I),
    .arready_o(S_AXI_ARREADY_O),
    .rdata_o(S_AXI_RDATA_O),
    .rresp_o(S_AXI_RRESP_O),
    .rvalid_o(S_AXI_RVALID_O),
    .rready_i(S_AXI_RREADY_I),
    .wr_en_o(wr_en),
    .wr_addr_o(wr_addr),
    .wr_data_o(wr_data),
    .wr_strb_o(wr_strb),
    .wr_err_i(!addr_ok(wr_addr)),
    .rd_addr_o(rd_addr),
    .rd_data_i(rd_data),
    .rd_err_i(!addr_ok(rd_addr))
  );

  always_ff @(posedge SYS_CLK_I) begin
    if (RST_I) begin
      ctrl_q <= `CSFS_CTRL_RST;
      max_speed_q <= `CSFS_MAX_SPEED_RST;
      settle_speed_q <= `CSFS_SETTLE_SPEED_RST;
      tolerance_q <= `CSFS_TOLERANCE_RST;
      brake_tmo_q <= `CSFS_BRAKE_TMO_RST;
      int_enable_q <= '0;
    end else if (wr_en) begin
      case (wr_addr)
        `CSFS_OFS_CTRL: ctrl_q <= merge(ctrl_q, wr_data, wr_strb) & 32'h0000_0007;
        `CSFS_OFS_MAX_SPEED: max_speed_q <= merge({16'h0000, max_speed_q}, wr_data, wr_strb)
                                              [15:0];
        `CSFS_OFS_SETTLE_SPEED: settle_speed_q <= merge({16'h0000, settle_speed_q}, wr_data,
                                                        wr_strb) [15:0];
        `CSFS_OFS_TOLERANCE: tolerance_q <= merge({16'h0000, tolerance_q}, wr_data, wr_strb)
                                              [15:0];
        `CSFS_OFS_BRAKE_TMO: brake_tmo_q <= merge({16'h0000, brake_tmo_q}, wr_data, wr_strb)
                                              [15:0];
        `CSFS_OFS_INT_ENABLE: int_enable_q <= merge({23'h0, int_enable_q}, wr_data, wr_strb)
                                                [`CSFS_NUM_EVT-1:0];
        default: ;
      endcase
    end
  end

  assign can_variant = ctrl_q[`CSFS_CTRL_CAN_BIT];
  assign brake_kind = ctrl_q[`CSFS_CTRL_KIND_MSB:`CSFS_CTRL_KIND_LSB];

  // ****************************************
  // creep sequencing faults
  // ****************************************
  logic [3:0] creep_sequence_fault_q;
  logic [3:0] pdo_cnt_q;
  logic [3:0] creep_set;
  logic [3:0] creep_clr;
  csfs_brk_t brk_q;
  logic [15:0] ms_cnt_q;
  logic [15:0] brk_ms_q;

  // received process messages, counted once per keyswitch cycle
  always_ff @(posedge SYS_CLK_I) begin
    if (RST_I) begin
      pdo_cnt_q <= 4'h0;
    end else if (PDO_RX_I && pdo_cnt_q != `CSFS_PDO_CLEAR) begin
      pdo_cnt_q <= pdo_cnt_q + 4'h1;
    end
  end

  // creep brake window timed in milliseconds
  always_ff @(posedge SYS_CLK_I) begin
    if (RST_I || !CREEP_BRAKE_STATE_I) begin
      brk_q <= CSFS_BRK_IDLE;
      ms_cnt_q <= 16'h0000;
      brk_ms_q <= 16'h0000;
    end else begin
      unique case (brk_q)
        CSFS_BRK_IDLE: begin
          brk_q <= CSFS_BRK_TIMING;
        end
        CSFS_BRK_TIMING: begin
          if (brk_ms_q >= brake_tmo_q) begin
            brk_q <= CSFS_BRK_EXPIRED;
          end else if (ms_cnt_q == MS_CYC - 16'h0001) begin
            ms_cnt_q <= 16'h0000;
            brk_ms_q <= brk_ms_q + 16'h0001;
          end else begin
            ms_cnt_q <= ms_cnt_q + 16'h0001;
          end
        end
        CSFS_BRK_EXPIRED: ;
        default: brk_q <= CSFS_BRK_IDLE;
      endcase
    end
  end

  always_comb begin
    creep_set[0] = can_variant ? (creep && PDO_RX_I && pdo_cnt_q < `CSFS_PDO_FIRST)
                               : (creep && ilock_on);
    creep_set[1] = ilock_off && creep;
    creep_set[2] = ilock_on && creep;
    creep_set[3] = brk_q == CSFS_BRK_TIMING && brake_exit && brake_kind != 2'b00;
    creep_clr[0] = !creep && (!can_variant || pdo_cnt_q == `CSFS_PDO_CLEAR);
    creep_clr[1] = !ilock && !creep;
    creep_clr[2] = !ilock && !creep;
    creep_clr[3] = brake_kind == 2'b00 || (MOTOR_RPM_I < settle_speed_q && !emr && !ilock
                                           && neutral);
  end

  // a set in the same cycle as a clear wins
  always_ff @(posedge SYS_CLK_I) begin
    if (RST_I) begin
      creep_sequence_fault_q <= 4'h0;
    end else begin
      creep_sequence_fault_q <= creep_set | (creep_sequence_fault_q & ~creep_clr);
    end
  end

  // ****************************************
  // speed supervision faults
  // ****************************************
  logic [18:0] rpm_x5;
  logic [18:0] max_x6;
  logic [16:0] curve_lim;
  logic off_curve;
  logic [4:0] speed_over;
  logic [4:0] speed_fault_q;

  assign rpm_x5 = 19'(MOTOR_RPM_I) * 19'd5;
  assign max_x6 = 19'(max_speed_q) * 19'd6;
  assign curve_lim = 17'(CURVE_RPM_I) + 17'(tolerance_q);
  assign off_curve = 17'(MOTOR_RPM_I) > curve_lim;

  csfs_dur_timer #(.LIMIT(OVERSPEED_CYC)) u_t_over (
    .clk_i(SYS_CLK_I),
    .rst_i(RST_I),
    .cond_i(rpm_x5 > max_x6),
    .over_o(speed_over[0])
  );

  csfs_dur_timer #(.LIMIT(CURVE_CYC)) u_t_decel (
    .clk_i(SYS_CLK_I),
    .rst_i(RST_I),
    .cond_i(off_curve && DECEL_I),
    .over_o(speed_over[1])
  );

  csfs_dur_timer #(.LIMIT(CURVE_CYC)) u_t_ilock (
    .clk_i(SYS_CLK_I),
    .rst_i(RST_I),
    .cond_i(off_curve && ILOCK_BRAKING_I),
    .over_o(speed_over[2])
  );

  csfs_dur_timer #(.LIMIT(CURVE_CYC)) u_t_emr (
    .clk_i(SYS_CLK_I),
    .rst_i(RST_I),
    .cond_i(off_curve && emr),
    .over_o(speed_over[3])
  );

  csfs_dur_timer #(.LIMIT(MAXSPEED_CYC)) u_t_max (
    .clk_i(SYS_CLK_I),
    .rst_i(RST_I),
    .cond_i(MOTOR_RPM_I > max_speed_q),
    .over_o(speed_over[4])
  );

  // latched until the keyswitch cycle resets the block
  always_ff @(posedge SYS_CLK_I) begin
    if (RST_I) begin
      speed_fault_q <= 5'h00;
    end else begin
      speed_fault_q <= speed_fault_q | speed_over;
    end
  end

  // ****************************************
  // actions, code and interrupt
  // ****************************************
  logic [`CSFS_NUM_EVT-1:0] evt;
  logic [`CSFS_NUM_EVT-1:0] evt_prev_q;
  logic [`CSFS_NUM_EVT-1:0] int_clr;

  // lowest active bit as a type number, 1-based
  function automatic logic [2:0] first_type(input logic [4:0] v);
    first_type = 3'd0;
    for (int i = 4; i >= 0; i--) begin
      if (v[i]) begin
        first_type = 3'(i + 1);
      end
    end
  endfunction

  always_ff @(posedge SYS_CLK_I) begin
    if (RST_I) begin
      THROTTLE_SHUTDOWN_O <= 1'b0;
      ILOCK_SHUTDOWN_O <= 1'b0;
      EMBRAKE_SHUTDOWN_O <= 1'b0;
      FAULT_GROUP_O <= CSFS_GRP_NONE;
      FAULT_TYPE_O <= 3'd0;
    end else begin
      THROTTLE_SHUTDOWN_O <= |creep_sequence_fault_q;
      ILOCK_SHUTDOWN_O <= |speed_fault_q;
      EMBRAKE_SHUTDOWN_O <= |speed_fault_q;
      if (|speed_fault_q) begin
        FAULT_GROUP_O <= CSFS_GRP_SPEED;
        FAULT_TYPE_O <= first_type(speed_fault_q);
      end else if (|creep_sequence_fault_q) begin
        FAULT_GROUP_O <= CSFS_GRP_CREEP;
        FAULT_TYPE_O <= first_type({1'b0, creep_sequence_fault_q});
      end else begin
        FAULT_GROUP_O <= CSFS_GRP_NONE;
        FAULT_TYPE_O <= 3'd0;
      end
    end
  end

  assign evt = {speed_fault_q, creep_sequence_fault_q};
  assign int_clr = (wr_en && wr_addr == `CSFS_OFS_INT_CLEAR) ? wr_data[`CSFS_NUM_EVT-1:0] : '0;

  // rising fault bits set sticky status; a set beats a clear in the same cycle
  always_ff @(posedge SYS_CLK_I) begin
    if (RST_I) begin
      evt_prev_q <= '0;
      int_status_q <= '0;
    end else begin
      evt_prev_q <= evt;
      int_status_q <= (evt & ~evt_prev_q) | (int_status_q & ~int_clr);
    end
  end

  assign IRQ_O = |(int_status_q & int_enable_q);

  always_comb begin
    rd_data = 32'h0000_0000;
    case (rd_addr)
      `CSFS_OFS_CTRL: rd_data = ctrl_q;
      `CSFS_OFS_MAX_SPEED: rd_data = {16'h0000, max_speed_q};
      `CSFS_OFS_SETTLE_SPEED: rd_data = {16'h0000, settle_speed_q};
      `CSFS_OFS_TOLERANCE: rd_data = {16'h0000, tolerance_q};
      `CSFS_OFS_BRAKE_TMO: rd_data = {16'h0000, brake_tmo_q};
      `CSFS_OFS_FAULTS: rd_data = {23'h0, evt};
      `CSFS_OFS_INT_STATUS: rd_data = {23'h0, int_status_q};
      `CSFS_OFS_INT_ENABLE: rd_data = {23'h0, int_enable_q};
      `CSFS_OFS_FAULT_CODE: rd_data = {27'h0, FAULT_TYPE_O, FAULT_GROUP_O};
      `CSFS_OFS_PDO_COUNT: rd_data = {28'h0, pdo_cnt_q};
      default: rd_data = 32'h0000_0000;
    endcase
  end

endmodule // csfs_supervisor

// ===== testbench/csfs_supervisor_checker.sv
// checker: shutdown and fault code relations at the supervisor ports
// assumes the reset maximum speed register and a bind into csfs_supervisor
`timescale 1ns/1ps
module csfs_sup_checker #(
  parameter logic [26:0] MAXSPEED_CYC = 27'd40
) (
  input wire logic SYS_CLK_I,
  input wire logic RST_I,
  input wire logic INTERLOCK_I,
  input wire logic CREEP_I,
  input wire logic [15:0] MOTOR_RPM_I,
  input wire logic THROTTLE_SHUTDOWN_O,
  input wire logic ILOCK_SHUTDOWN_O,
  input wire logic EMBRAKE_SHUTDOWN_O,
  input wire logic [1:0] FAULT_GROUP_O,
  input wire logic [2:0] FAULT_TYPE_O
);
  default clocking @(posedge SYS_CLK_I); endclocking
  default disable iff (RST_I);
  logic [26:0] over_q;
  // consecutive cycles above the reset maximum speed
  always_ff @(posedge SYS_CLK_I) begin
    if (RST_I || MOTOR_RPM_I <= 16'h0fa0) over_q <= '0;
    else if (over_q != '1) over_q <= over_q + 27'd1;
  end
  property p_pair; ILOCK_SHUTDOWN_O == EMBRAKE_SHUTDOWN_O; endproperty
  a_pair: assert property (p_pair) else $error("shutdowns differ");
  property p_latch; ILOCK_SHUTDOWN_O |=> ILOCK_SHUTDOWN_O; endproperty
  a_latch: assert property (p_latch) else $error("speed fault dropped");
  property p_grp; ILOCK_SHUTDOWN_O |-> FAULT_GROUP_O == 2'd2 && FAULT_TYPE_O inside {[3'd1:3'd5]};
  endproperty
  a_grp: assert property (p_grp) else $error("speed code wrong");
  property p_none; FAULT_GROUP_O == 2'd0 |-> FAULT_TYPE_O == 3'd0 && !THROTTLE_SHUTDOWN_O;
  endproperty
  a_none: assert property (p_none) else $error("idle code wrong");
  property p_creep; FAULT_GROUP_O == 2'd1 |-> THROTTLE_SHUTDOWN_O && FAULT_TYPE_O inside {[3'd1:3'd4]};
  endproperty
  a_creep: assert property (p_creep) else $error("creep code wrong");
  property p_seq; $rose(INTERLOCK_I) && $past(CREEP_I) ##1 (INTERLOCK_I && CREEP_I)[*8]
    |-> THROTTLE_SHUTDOWN_O; endproperty
  a_seq: assert property (p_seq) else $error("no creep start fault");
  property p_hold; (INTERLOCK_I && CREEP_I)[*5] ##0 THROTTLE_SHUTDOWN_O |=> THROTTLE_SHUTDOWN_O;
  endproperty
  a_hold: assert property (p_hold) else $error("creep fault cleared early");
  property p_spd5; over_q == MAXSPEED_CYC + 27'd2 |-> ##[0:4] ILOCK_SHUTDOWN_O; endproperty
  a_spd5: assert property (p_spd5) else $error("no overspeed fault");
  c_brk: cover property (FAULT_GROUP_O == 2'd1 && FAULT_TYPE_O == 3'd4);
  c_max: cover property (ILOCK_SHUTDOWN_O && FAULT_TYPE_O == 3'd5);
  c_clr: cover property ($fell(THROTTLE_SHUTDOWN_O));
endmodule // csfs_sup_checker
bind csfs_supervisor csfs_sup_checker #(.MAXSPEED_CYC(MAXSPEED_CYC)) u_chk (.SYS_CLK_I,
  .RST_I, .INTERLOCK_I, .CREEP_I, .MOTOR_RPM_I, .THROTTLE_SHUTDOWN_O, .ILOCK_SHUTDOWN_O,
  .EMBRAKE_SHUTDOWN_O, .FAULT_GROUP_O, .FAULT_TYPE_O);

// ===== testbench/csfs_supervisor_tb.sv
// self-checking bench of the creep and speed fault supervisor
// assumes shortened timer parameters and the vehicle model on the pins
`timescale 1ns/1ps
module csfs_supervisor_tb;
  logic clk, rst, awv, wv, bre, arv, rre, pdo, cbs, dec, ilb, awr, wrd, bv, arr, rv;
  logic thr, ilk, emb, irq;
  logic [7:0] awa, ara;
  logic [31:0] wd, rd, rdat;
  logic [1:0] rr, brsp, rrsp, grp;
  logic [2:0] typ;
  logic [4:0] sw, pin;
  logic [15:0] rpm, crv, mrpm, r;
  integer n_errors = 0, n_compared = 0, seed = 32'hbbb6b73a, i;
  csfs_vehicle_model u_veh (.clk_i(clk), .sw_i(sw), .rpm_i(rpm), .pin_o(pin), .rpm_o(mrpm));
  csfs_supervisor #(.OVERSPEED_CYC(27'd20), .CURVE_CYC(27'd8), .MAXSPEED_CYC(27'd40),
    .MS_CYC(16'd4)) DUT (.SYS_CLK_I(clk), .RST_I(rst), .INTERLOCK_I(pin[4]),
    .CREEP_I(pin[3]), .EMR_I(pin[2]), .THROTTLE_NEUTRAL_I(pin[1]), .BRAKE_EXIT_I(pin[0]),
    .CREEP_BRAKE_STATE_I(cbs), .DECEL_I(dec), .ILOCK_BRAKING_I(ilb), .PDO_RX_I(pdo),
    .MOTOR_RPM_I(mrpm), .CURVE_RPM_I(crv), .S_AXI_AWADDR_I(awa), .S_AXI_AWVALID_I(awv),
    .S_AXI_AWREADY_O(awr), .S_AXI_WDATA_I(wd), .S_AXI_WSTRB_I(4'hf), .S_AXI_WVALID_I(wv),
    .S_AXI_WREADY_O(wrd), .S_AXI_BRESP_O(brsp), .S_AXI_BVALID_O(bv), .S_AXI_BREADY_I(bre),
    .S_AXI_ARADDR_I(ara), .S_AXI_ARVALID_I(arv), .S_AXI_ARREADY_O(arr),
    .S_AXI_RDATA_O(rdat), .S_AXI_RRESP_O(rrsp), .S_AXI_RVALID_O(rv), .S_AXI_RREADY_I(rre),
    .THROTTLE_SHUTDOWN_O(thr), .ILOCK_SHUTDOWN_O(ilk), .EMBRAKE_SHUTDOWN_O(emb),
    .FAULT_GROUP_O(grp), .FAULT_TYPE_O(typ), .IRQ_O(irq));
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_compared++;
    if (g !== e) begin
      n_errors++;
      $display("[FAIL] %0t got %h expected %h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic ap, wp;
    ap = 1'b1;
    wp = 1'b1;
    awa <= a;
    wd <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    bre <= 1'b1;
    while (ap || wp) begin
      @(posedge clk);
      if (ap && awr) begin
        ap = 1'b0;
        awv <= 1'b0;
      end
      if (wp && wrd) begin
        wp = 1'b0;
        wv <= 1'b0;
      end
    end
    do @(posedge clk); while (!bv);
    rr = brsp;
    bre <= 1'b0;
  endtask
  task automatic rdr(input logic [7:0] a);
    ara <= a;
    arv <= 1'b1;
    rre <= 1'b1;
    do @(posedge clk); while (!arr);
    arv <= 1'b0;
    do @(posedge clk); while (!rv);
    rd = rdat;
    rr = rrsp;
    rre <= 1'b0;
  endtask
  function automatic int lim(input int k);
    return k == 0 ? 20 : k == 4 ? 40 : 8;
  endfunction
  task automatic drive(input int k, input logic on);
    rpm <= !on ? 16'h0 : k == 0 ? 16'h1400 + r : k == 4 ? 16'h0fa1 + 3 * r : crv + 16'h00c9 + r;
    dec <= on && k == 1;
    ilb <= on && k == 2;
    sw <= {2'b00, on && k == 3, 2'b10};
  endtask
  task automatic test_done;
    $display("errors %0d compared %0d", n_errors, n_compared);
    if (n_errors == 0 && n_compared > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  initial begin
    cyc(20000);
    n_errors++;
    $display("[FAIL] %0t timeout", $time);
    test_done;
  end
  initial begin
    {awv, wv, bre, arv, rre, pdo, cbs, dec, ilb} = '0;
    {awa, ara, wd, r, rpm} = '0;
    crv = 16'h0100;
    sw = 5'b00010;
    rst = 1'b1;
    cyc(12);
    rst <= 1'b0;
    cyc(1);
    rdr(8'h00);
    chk(rd, 32'h2);
    rdr(8'h2c);
    chk(32'(rr), 32'h2);
    wr(8'h2c, 32'h1);
    chk(32'(rr), 32'h2);
    wr(8'h20, 32'h1ff);
    chk(32'(rr), 32'h0);
    sw <= 5'b01010;
    cyc(8);
    sw <= 5'b11010;
    cyc(10);
    rdr(8'h14);
    chk(rd, 32'h5);
    chk({thr, irq}, 2'b11);
    sw <= 5'b01010;
    cyc(10);
    rdr(8'h14);
    chk(rd, 32'h7);
    wr(8'h1c, 32'h1ff);
    chk(irq, 1'b0);
    sw <= 5'b00010;
    cyc(10);
    chk({thr, grp}, 3'b000);
    $display("test creep sequence done");
    wr(8'h00, 32'h3);
    sw <= 5'b01010;
    cyc(8);
    pdo <= 1'b1;
    cyc(1);
    pdo <= 1'b0;
    sw <= 5'b00010;
    cyc(8);
    rdr(8'h14);
    chk(rd, 32'h1);
    repeat (10) begin
      pdo <= 1'b1;
      cyc(1);
      pdo <= 1'b0;
      cyc(1);
    end
    rdr(8'h28);
    chk(rd, 32'd11);
    rdr(8'h14);
    chk(rd, 32'h0);
    wr(8'h00, 32'h2);
    cbs <= 1'b1;
    sw <= 5'b00001;
    cyc(1);
    sw <= 5'b00000;
    cyc(10);
    chk({grp, typ}, 5'b01100);
    cbs <= 1'b0;
    sw <= 5'b00010;
    cyc(10);
    chk(thr, 1'b0);
    wr(8'h00, 32'h0);
    cbs <= 1'b1;
    sw <= 5'b00001;
    cyc(1);
    sw <= 5'b00000;
    cyc(10);
    chk(thr, 1'b0);
    cbs <= 1'b0;
    sw <= 5'b00010;
    $display("test bus variant and brake done");
    for (i = 0; i < 5; i++) begin
      rst <= 1'b1;
      cyc(2);
      rst <= 1'b0;
      r = 16'($unsigned($random(seed)) % 256);
      drive(i, 1'b1);
      cyc(lim(i) - 2);
      drive(i, 1'b0);
      cyc(1);
      drive(i, 1'b1);
      cyc(lim(i) - 2);
      drive(i, 1'b0);
      cyc(6);
      chk(ilk, 1'b0);
      drive(i, 1'b1);
      cyc(lim(i) + 10);
      drive(i, 1'b0);
      cyc(3);
      chk({ilk, emb, grp, typ}, {4'b1110, 3'(i + 1)});
    end
    $display("test speed supervision done");
    test_done;
  end
endmodule // csfs_supervisor_tb

// ===== testbench/csfs_vehicle_model.sv
// vehicle side: switch pins, speed feedback and brake exit
// assumes commands from the bench on the system clock
`timescale 1ns/1ps
module csfs_vehicle_model (
  input wire logic clk_i,
  input wire logic [4:0] sw_i,
  input wire logic [15:0] rpm_i,
  output logic [4:0] pin_o,
  output logic [15:0] rpm_o
);
  logic [1:0] ext_q;
  initial begin
    pin_o = 5'h02;
    rpm_o = 16'h0000;
    ext_q = 2'd0;
  end
  // pins are interlock, creep, reverse, neutral, brake exit
  always @(posedge clk_i) begin
    rpm_o <= rpm_i;
    pin_o <= {sw_i[4:1], sw_i[0] | (ext_q != 2'd0)};
    ext_q <= sw_i[0] ? 2'd3 : ext_q - {1'b0, ext_q != 2'd0};
  end
endmodule // csfs_vehicle_model
